// ===== urm_baud.sv
`timescale 1ns/1ps
`include "urm_defs.svh"

module urm_baud import urm_pkg::*; #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] divisor,
    input wire logic reload,
    output logic tick
);

    logic [WIDTH-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;

    // down counter, one tick per divisor cycles; a zero divisor stops it
    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (reload || divisor == '0) begin
            cnt_d = divisor;
        end else if (cnt_q <= WIDTH'(1)) begin
            cnt_d = divisor;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q - WIDTH'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule

// ===== urm_defs.svh
`ifndef URM_DEFS_SVH
`define URM_DEFS_SVH

// ************************************************************
// register offsets on the three address lines
// ************************************************************
`define URM_A_DATA 3'h0
`define URM_A_IER 3'h1
`define URM_A_ISR 3'h2
`define URM_A_LCR 3'h3
`define URM_A_MCR 3'h4
`define URM_A_LSR 3'h5
`define URM_A_MSR 3'h6
`define URM_A_SPR 3'h7

// ************************************************************
// field positions and masks
// ************************************************************
`define URM_LCR_DLAB 7
`define URM_LCR_ENH_KEY 8'hbf
`define URM_EFR_ENH 4
`define URM_FCR_EN 0
`define URM_FCR_RXRST 1
`define URM_IER_RX 0
`define URM_IER_TX 1
`define URM_IER_LS 2
`define URM_IER_MS 3
`define URM_IER_ENH_MASK 8'hf0
`define URM_MCR_ENH_MASK 8'he4
`define URM_FCR_ENH_MASK 8'h30

// ************************************************************
// interrupt source codes for irq_status bits 3:0
// ************************************************************
`define URM_ISR_NONE 4'h1
`define URM_ISR_LSR 4'h6
`define URM_ISR_RXRDY 4'h4
`define URM_ISR_TXRDY 4'h2
`define URM_ISR_MSR 4'h0

// ************************************************************
// receive trigger levels and reset values
// ************************************************************
`define URM_TRIG_0 5'h01
`define URM_TRIG_1 5'h04
`define URM_TRIG_2 5'h08
`define URM_TRIG_3 5'h0e
`define URM_FIFO_DEPTH 16
`define URM_REG_RST 8'h00
`define URM_DIV_RST 16'h0000

`endif

// ===== urm_host.sv
`timescale 1ns/1ps
// **********
// host processor on the byte bus
// **********
module urm_host import urm_pkg::*; (
    input wire logic clk,
    input wire logic [7:0] d_out,
    input wire logic d_oe,
    output urm_bus_t bus
);
    // deselected idle bus
    initial begin
        bus = 14'h3800;
    end
    // write: strobe low four cycles, data kept three past it, then lines flipped
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        bus = {3'b010, a, d};
        repeat (4) @(negedge clk);
        bus.wr_n = 1'b1;
        repeat (3) @(negedge clk);
        bus = {3'b111, ~a, ~d};
        repeat (4) @(negedge clk);
    endtask
    // read: hold strobe until the device drives, take data, release
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        bus = {3'b001, a, bus.data};
        while (d_oe !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        d = (n < 20) ? d_out : 8'hxx;
        bus = {3'b111, ~a, bus.data};
        repeat (4) @(negedge clk);
    endtask
endmodule

// ===== urm_pkg.sv
package urm_pkg;

    // ************************************************************
    // bus access state, one-hot
    // ************************************************************
    typedef enum logic [2:0] {
        URM_ACC_IDLE = 3'b001,
        URM_ACC_RD = 3'b010,
        URM_ACC_WR = 3'b100
    } urm_acc_t;

    // ************************************************************
    // decoded register selects
    // ************************************************************
    typedef enum logic [3:0] {
        URM_SEL_DATA, URM_SEL_DLL, URM_SEL_REV, URM_SEL_IER, URM_SEL_DLM,
        URM_SEL_IDENT, URM_SEL_ISR, URM_SEL_EFR, URM_SEL_LCR, URM_SEL_MCR,
        URM_SEL_LSR, URM_SEL_MSR, URM_SEL_SPR, URM_SEL_FLOW_ON_CHAR_1, URM_SEL_FLOW_ON_CHAR_2,
        URM_SEL_XOFF
    } urm_sel_t;

    // sampled host bus pins
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [2:0] addr;
        logic [7:0] data;
    } urm_bus_t;

    // one receive fifo entry: break, framing, parity flags and the character
    typedef struct packed {
        logic [2:0] err;
        logic [7:0] data;
    } urm_rx_entry_t;

endpackage

// ===== urm_top.sv
`timescale 1ns/1ps
`include "urm_defs.svh"

// Behaviour
// - the host picks one byte register by three address lines under chip select.
// - a sixteen-bit baud divider counter loaded from the divisor latches makes the rate tick.
// - divisor latches sit at addresses 0 and 1 only while line_control bit 7 is one.
// - irq_enable masks the rx data, tx empty, line status and modem status sources.
// - with fifos and rx interrupt enabled the interrupt rises when the fill reaches the trigger.
// - the rx data interrupt drops as soon as the fill falls below the trigger.
// - the rx source code shows in irq_status bits 3:0 and clears together with the interrupt.
// - line_status bit 0 is set as a character enters the receive fifo.
// - line_status bit 0 clears only when the receive fifo is empty.
// - enhanced bits are writable and effective only while enhanced_features bit 4 is one.
// - irq_status bits 7:6 read one with fifos enabled and zero otherwise.
module urm_top import urm_pkg::*; #(
    parameter int DEPTH = `URM_FIFO_DEPTH,
    parameter logic [7:0] REV_CODE = 8'h03, // arbitrary value
    parameter logic [7:0] IDENT_CODE = 8'h5a // arbitrary value
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] D_IN,
    output logic [7:0] D_OUT,
    output logic D_OE,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic [2:0] RX_ERR,
    input wire logic THR_EMPTY,
    input wire logic TX_ALL_EMPTY,
    output logic TX_WR,
    output logic [7:0] TX_DATA,
    input wire logic [3:0] MODEM_N,
    output logic [7:0] LINE_CTRL,
    output logic [7:0] MODEM_CTRL,
    output logic [1:0] TX_TRIG,
    output logic BAUD_TICK,
    output logic INT
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // ************************************************************
    // decode helpers
    // ************************************************************

    // address decode qualified by the divisor and enhanced keys
    function automatic urm_sel_t urm_decode(input logic [2:0] a, input logic [7:0] line_control,
                                            input logic dl_zero, input logic rd);
        logic key;
        key = (line_control == `URM_LCR_ENH_KEY);
        case (a)
            `URM_A_DATA: urm_decode = !line_control[`URM_LCR_DLAB] ? URM_SEL_DATA :
                                      (rd && dl_zero) ? URM_SEL_REV : URM_SEL_DLL;
            `URM_A_IER: urm_decode = !line_control[`URM_LCR_DLAB] ? URM_SEL_IER :
                                     (rd && dl_zero) ? URM_SEL_IDENT : URM_SEL_DLM;
            `URM_A_ISR: urm_decode = key ? URM_SEL_EFR : URM_SEL_ISR;
            `URM_A_LCR: urm_decode = URM_SEL_LCR;
            `URM_A_MCR: urm_decode = key ? URM_SEL_FLOW_ON_CHAR_1 : URM_SEL_MCR;
            `URM_A_LSR: urm_decode = key ? URM_SEL_FLOW_ON_CHAR_2 : URM_SEL_LSR;
            `URM_A_MSR: urm_decode = key ? URM_SEL_XOFF : URM_SEL_MSR;
            default: urm_decode = key ? URM_SEL_XOFF : URM_SEL_SPR;
        endcase
    endfunction

    // trigger select to fill level
    function automatic logic [CW-1:0] urm_trig(input logic [1:0] s);
        case (s)
            2'h0: urm_trig = CW'(`URM_TRIG_0);
            2'h1: urm_trig = CW'(`URM_TRIG_1);
            2'h2: urm_trig = CW'(`URM_TRIG_2);
            default: urm_trig = CW'(`URM_TRIG_3);
        endcase
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    urm_bus_t bus_s1_q, bus_s2_q;
    logic [3:0] mdm_s1_q, mdm_s2_q, mdm_prev_q;

    // two flops on every bus and modem pin; the second stage is read, and mdm_prev_q delays it once more for the modem deltas
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            bus_s1_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0, data: 8'h00};
            bus_s2_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0, data: 8'h00};
            mdm_s1_q <= 4'hf;
            mdm_s2_q <= 4'hf;
            mdm_prev_q <= 4'hf;
        end else begin
            bus_s1_q <= '{cs_n: CS_N, rd_n: RD_N, wr_n: WR_N, addr: ADDR, data: D_IN};
            bus_s2_q <= bus_s1_q;
            mdm_s1_q <= MODEM_N;
            mdm_s2_q <= mdm_s1_q;
            mdm_prev_q <= mdm_s2_q;
        end
    end

    // ************************************************************
    // host access sequencer
    // ************************************************************
    urm_acc_t acc_q, acc_d;
    logic [2:0] wa_q, wa_d;
    logic [7:0] wd_q, wd_d;
    logic rd_go, wr_go;

    // read acts on the strobe's leading edge, write on its trailing edge
    always_comb begin
        acc_d = acc_q;
        wa_d = wa_q;
        wd_d = wd_q;
        rd_go = 1'b0;
        wr_go = 1'b0;
        case (acc_q)
            URM_ACC_IDLE: begin
                if (!bus_s2_q.cs_n && !bus_s2_q.rd_n) begin
                    acc_d = URM_ACC_RD;
                    rd_go = 1'b1;
                end else if (!bus_s2_q.cs_n && !bus_s2_q.wr_n) begin
                    acc_d = URM_ACC_WR;
                end
            end
            URM_ACC_RD: begin
                if (bus_s2_q.rd_n) begin
                    acc_d = URM_ACC_IDLE;
                end
            end
            URM_ACC_WR: begin
                if (bus_s2_q.wr_n) begin
                    acc_d = URM_ACC_IDLE;
                    wr_go = 1'b1;
                end else begin
                    wa_d = bus_s2_q.addr;
                    wd_d = bus_s2_q.data;
                end
            end
            default: acc_d = URM_ACC_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            acc_q <= URM_ACC_IDLE;
            wa_q <= 3'h0;
            wd_q <= 8'h00;
        end else begin
            acc_q <= acc_d;
            wa_q <= wa_d;
            wd_q <= wd_d;
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [7:0] lcr_q, ier_q, efr_q, mcr_q, spr_q, dll_q, dlm_q;
    logic [7:0] lcr_d, ier_d, efr_d, mcr_d, spr_d, dll_d, dlm_d;
    logic [7:0] flow_on_char_1_q, flow_on_char_2_q, flow_off_char_1_q, flow_off_char_2_q, flow_on_char_1_d, flow_on_char_2_d, flow_off_char_1_d, flow_off_char_2_d;
    logic [7:0] thr_q, thr_d;
    logic fen_q, fen_d, txwr_q, txwr_d, rxrst;
    logic [1:0] rtrig_q, rtrig_d, ttrig_q, ttrig_d;
    logic enh, dl_zero;
    logic [7:0] ier_eff, mcr_eff, enh_keep;
    urm_sel_t wsel, rsel;

    assign enh = efr_q[`URM_EFR_ENH];
    assign enh_keep = enh ? 8'hff : 8'h00;
    assign ier_eff = ier_q & (enh_keep | ~`URM_IER_ENH_MASK);
    assign mcr_eff = mcr_q & (enh_keep | ~`URM_MCR_ENH_MASK);
    assign dl_zero = (dll_q == 8'h00) && (dlm_q == 8'h00);
    assign wsel = urm_decode(wa_q, lcr_q, dl_zero, 1'b0);
    assign rsel = urm_decode(bus_s2_q.addr, lcr_q, dl_zero, 1'b1);

    // register writes; enhanced bits only land while enhanced access is on
    always_comb begin
        {lcr_d, ier_d, efr_d, mcr_d, spr_d} = {lcr_q, ier_q, efr_q, mcr_q, spr_q};
        {dll_d, dlm_d, thr_d, fen_d, rtrig_d, ttrig_d} =
            {dll_q, dlm_q, thr_q, fen_q, rtrig_q, ttrig_q};
        {flow_on_char_1_d, flow_on_char_2_d, flow_off_char_1_d, flow_off_char_2_d} = {flow_on_char_1_q, flow_on_char_2_q, flow_off_char_1_q, flow_off_char_2_q};
        txwr_d = 1'b0;
        rxrst = 1'b0;
        if (wr_go) begin
            case (wsel)
                URM_SEL_DATA: begin
                    thr_d = wd_q;
                    txwr_d = 1'b1;
                end
                URM_SEL_DLL: dll_d = wd_q;
                URM_SEL_DLM: dlm_d = wd_q;
                URM_SEL_IER: ier_d = wd_q & (enh_keep | ~`URM_IER_ENH_MASK);
                URM_SEL_ISR: begin
                    fen_d = wd_q[`URM_FCR_EN];
                    rxrst = wd_q[`URM_FCR_RXRST] || (wd_q[`URM_FCR_EN] != fen_q);
                    rtrig_d = wd_q[7:6];
                    ttrig_d = enh ? wd_q[5:4] : 2'h0;
                end
                URM_SEL_EFR: efr_d = wd_q;
                URM_SEL_LCR: lcr_d = wd_q;
                URM_SEL_MCR: mcr_d = wd_q & (enh_keep | ~`URM_MCR_ENH_MASK);
                URM_SEL_SPR: spr_d = wd_q;
                URM_SEL_FLOW_ON_CHAR_1: flow_on_char_1_d = wd_q;
                URM_SEL_FLOW_ON_CHAR_2: flow_on_char_2_d = wd_q;
                URM_SEL_XOFF: begin
                    if (wa_q == `URM_A_MSR) begin
                        flow_off_char_1_d = wd_q;
                    end else begin
                        flow_off_char_2_d = wd_q;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            {lcr_q, ier_q, efr_q, mcr_q, spr_q} <= {5{`URM_REG_RST}};
            {dlm_q, dll_q} <= `URM_DIV_RST;
            {flow_on_char_1_q, flow_on_char_2_q, flow_off_char_1_q, flow_off_char_2_q, thr_q} <= {5{`URM_REG_RST}};
            fen_q <= 1'b0;
            rtrig_q <= 2'h0;
            ttrig_q <= 2'h0;
            txwr_q <= 1'b0;
        end else begin
            {lcr_q, ier_q, efr_q, mcr_q, spr_q} <= {lcr_d, ier_d, efr_d, mcr_d, spr_d};
            {dll_q, dlm_q, thr_q, fen_q} <= {dll_d, dlm_d, thr_d, fen_d};
            {rtrig_q, ttrig_q, txwr_q} <= {rtrig_d, ttrig_d, txwr_d};
            {flow_on_char_1_q, flow_on_char_2_q, flow_off_char_1_q, flow_off_char_2_q} <= {flow_on_char_1_d, flow_on_char_2_d, flow_off_char_1_d, flow_off_char_2_d};
        end
    end

    // ************************************************************
    // receive fifo
    // ************************************************************
    urm_rx_entry_t mem_q [DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic ovr_q, ovr_d, full, push, pop, any_err;
    urm_rx_entry_t head;

    // without fifos the store holds a single character
    assign full = fen_q ? (cnt_q == CW'(DEPTH)) : (cnt_q != '0);
    assign push = RX_VALID && !full;
    assign pop = rd_go && (rsel == URM_SEL_DATA) && (cnt_q != '0);
    assign head = mem_q[rp_q];

    // pointers, fill count and the sticky overrun; the set wins over the read clear
    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            wp_d = wp_q + PW'(1);
        end
        if (pop) begin
            rp_d = rp_q + PW'(1);
        end
        cnt_d = cnt_q + CW'(push) - CW'(pop);
        if (rxrst) begin
            wp_d = '0;
            rp_d = '0;
            cnt_d = '0;
        end
        ovr_d = ovr_q && !(rd_go && rsel == URM_SEL_LSR);
        if (RX_VALID && full) begin
            ovr_d = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            ovr_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            ovr_q <= ovr_d;
        end
    end

    // storage array, written on push only
    always_ff @(posedge CLK) begin
        if (push) begin
            mem_q[wp_q] <= '{err: RX_ERR, data: RX_DATA};
        end
    end

    // error flag of any character still waiting
    always_comb begin
        logic [PW-1:0] off;
        off = '0;
        any_err = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            off = PW'(i) - rp_q;
            if ((CW'(off) < cnt_q) && (mem_q[i].err != 3'h0)) begin
                any_err = 1'b1;
            end
        end
    end

    // ************************************************************
    // status and interrupt sources
    // ************************************************************
    logic [7:0] line_status, modem_status, irq_status;
    logic [3:0] dlt_q, dlt_d;
    logic txf_q, txf_d, thr_prev_q, ier_tx_prev_q, int_q;
    logic src_ls, src_rx, src_tx, src_ms;
    logic [3:0] code;

    // data ready follows the fill count, so a host read never drops it early
    assign line_status = {fen_q && any_err, TX_ALL_EMPTY, THR_EMPTY,
                  (cnt_q != '0) ? head.err : 3'h0, ovr_q, cnt_q != '0};
    assign modem_status = {~mdm_s2_q, dlt_q};

    assign src_ls = ier_eff[`URM_IER_LS] && (line_status[4:1] != 4'h0);
    assign src_rx = ier_eff[`URM_IER_RX] &&
                    (fen_q ? (cnt_q >= urm_trig(rtrig_q)) : (cnt_q != '0));
    assign src_tx = ier_eff[`URM_IER_TX] && txf_q;
    assign src_ms = ier_eff[`URM_IER_MS] && (dlt_q != 4'h0);

    // highest pending source wins the code; rx code drops with the fill level
    always_comb begin
        if (src_ls) begin
            code = `URM_ISR_LSR;
        end else if (src_rx) begin
            code = `URM_ISR_RXRDY;
        end else if (src_tx) begin
            code = `URM_ISR_TXRDY;
        end else if (src_ms) begin
            code = `URM_ISR_MSR;
        end else begin
            code = `URM_ISR_NONE;
        end
    end

    assign irq_status = {fen_q, fen_q, 2'h0, code};

    // modem deltas and tx-ready flag; a new event beats a read clear
    always_comb begin
        dlt_d = dlt_q;
        if (rd_go && rsel == URM_SEL_MSR) begin
            dlt_d = 4'h0;
        end
        dlt_d = dlt_d | (mdm_s2_q ^ mdm_prev_q);
        txf_d = txf_q;
        if ((rd_go && rsel == URM_SEL_ISR && code == `URM_ISR_TXRDY) ||
            (wr_go && wsel == URM_SEL_DATA)) begin
            txf_d = 1'b0;
        end
        if (THR_EMPTY && (!thr_prev_q || !ier_tx_prev_q) && ier_eff[`URM_IER_TX]) begin
            txf_d = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            dlt_q <= 4'h0;
            txf_q <= 1'b0;
            thr_prev_q <= 1'b1;
            ier_tx_prev_q <= 1'b0;
            int_q <= 1'b0;
        end else begin
            dlt_q <= dlt_d;
            txf_q <= txf_d;
            thr_prev_q <= THR_EMPTY;
            ier_tx_prev_q <= ier_eff[`URM_IER_TX];
            int_q <= (code != `URM_ISR_NONE);
        end
    end

    // ************************************************************
    // read data path
    // ************************************************************
    logic [7:0] dout_q, dout_d;

    // read mux captured on the leading edge of the read strobe
    always_comb begin
        dout_d = dout_q;
        if (rd_go) begin
            case (rsel)
                URM_SEL_DATA: dout_d = head.data;
                URM_SEL_DLL: dout_d = dll_q;
                URM_SEL_REV: dout_d = REV_CODE;
                URM_SEL_IER: dout_d = ier_eff;
                URM_SEL_DLM: dout_d = dlm_q;
                URM_SEL_IDENT: dout_d = IDENT_CODE;
                URM_SEL_ISR: dout_d = irq_status;
                URM_SEL_EFR: dout_d = efr_q;
                URM_SEL_LCR: dout_d = lcr_q;
                URM_SEL_MCR: dout_d = mcr_eff;
                URM_SEL_LSR: dout_d = line_status;
                URM_SEL_MSR: dout_d = modem_status;
                URM_SEL_SPR: dout_d = spr_q;
                URM_SEL_FLOW_ON_CHAR_1: dout_d = flow_on_char_1_q;
                URM_SEL_FLOW_ON_CHAR_2: dout_d = flow_on_char_2_q;
                default: dout_d = (bus_s2_q.addr == `URM_A_MSR) ? flow_off_char_1_q : flow_off_char_2_q;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            dout_q <= 8'h00;
        end else begin
            dout_q <= dout_d;
        end
    end

    // ************************************************************
    // baud divider and outputs
    // ************************************************************
    urm_baud #(.WIDTH(16)) u_baud (
        .clk(CLK),
        .resetn(RESETN),
        .divisor({dlm_q, dll_q}),
        .reload(wr_go && (wsel == URM_SEL_DLL || wsel == URM_SEL_DLM)),
        .tick(BAUD_TICK)
    );

    assign D_OUT = dout_q;
    assign D_OE = (acc_q == URM_ACC_RD) && !rd_go;
    assign TX_WR = txwr_q;
    assign TX_DATA = thr_q;
    assign LINE_CTRL = lcr_q;
    assign MODEM_CTRL = mcr_eff;
    assign TX_TRIG = enh ? ttrig_q : 2'h0;
    assign INT = int_q;

endmodule

// ===== urm_top_asserts.sv
`timescale 1ns/1ps
// **********
// port checks of the register bank
// **********
module urm_asserts (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic RX_VALID,
    input wire logic [7:0] D_OUT,
    input wire logic D_OE,
    input wire logic TX_WR,
    input wire logic [7:0] LINE_CTRL,
    input wire logic [7:0] MODEM_CTRL,
    input wire logic BAUD_TICK,
    input wire logic INT,
    input wire logic [3:0] MODEM_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    logic [3:0] wr_q, wr_d, act_q, act_d;
    // cycles since a write strobe, and since any strobe, character or active modem pin
    always_comb begin
        wr_d = !WR_N ? 4'h0 : wr_q + {3'h0, wr_q != 4'hf};
        act_d = (!WR_N || !RD_N || RX_VALID || MODEM_N != 4'hf) ? 4'h0 :
                act_q + {3'h0, act_q != 4'hf};
    end
    // counters start saturated so nothing counts as recent after reset
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_q <= 4'hf;
            act_q <= 4'hf;
        end else begin
            wr_q <= wr_d;
            act_q <= act_d;
        end
    end
    a_oe_cause: assert property ($rose(D_OE) |-> !$past(RD_N, 2) && !$past(CS_N, 2))
        else $error("bus driven without a read");
    a_oe_release: assert property (RD_N [*5] |-> !D_OE)
        else $error("bus still driven after read");
    a_oe_write: assert property (!WR_N |-> !D_OE)
        else $error("bus driven during write");
    a_dout_hold: assert property (D_OE && $past(D_OE) |-> $stable(D_OUT))
        else $error("read data moved while driven");
    a_lcr_write: assert property (!$stable(LINE_CTRL) |-> wr_q <= 4'h8)
        else $error("line control moved without write");
    a_mcr_write: assert property (!$stable(MODEM_CTRL) |-> wr_q <= 4'h8)
        else $error("modem control moved without write");
    a_tx_write: assert property (TX_WR |-> wr_q <= 4'h8)
        else $error("tx write without host write");
    a_int_rise: assert property ($rose(INT) |-> act_q <= 4'h8)
        else $error("interrupt rose without cause");
    a_int_fall: assert property ($fell(INT) |-> act_q <= 4'h8)
        else $error("interrupt fell without cause");
    cover property ($rose(INT));
    cover property ($fell(INT));
    cover property (BAUD_TICK);
endmodule

// ===== urm_top_tb_top.sv
`timescale 1ns/1ps
module urm_top_tb_top import urm_pkg::*; ;
    typedef struct packed {
        logic [7:0] line_control;
        logic [2:0] a;
        logic [7:0] wd;
        logic [7:0] ex;
    } urm_row_t;
    localparam logic [7:0] REV = 8'h21; // arbitrary value
    localparam logic [7:0] IDENT = 8'h6c; // arbitrary value
    // rows: line control, address, byte written, byte read back
    localparam urm_row_t ROWS [10] = '{
        '{8'h80, 3'h0, 8'h00, REV}, '{8'h80, 3'h1, 8'h00, IDENT},
        '{8'h80, 3'h0, 8'h05, 8'h05}, '{8'h80, 3'h1, 8'h00, 8'h00},
        '{8'h00, 3'h1, 8'hf1, 8'h01}, '{8'h00, 3'h7, 8'ha5, 8'ha5},
        '{8'h00, 3'h4, 8'he4, 8'h00}, '{8'hbf, 3'h2, 8'h10, 8'h10},
        '{8'hbf, 3'h4, 8'h5a, 8'h5a}, '{8'h00, 3'h4, 8'he4, 8'he4}};
    logic clk = 1'b0, resetn = 1'b0, rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00, r, d_out, tx_data, line_ctrl, modem_ctrl;
    logic d_oe, tx_wr, baud_tick, irq;
    logic [1:0] tx_trig;
    logic [3:0] modem_n = 4'hf;
    urm_bus_t bus;
    int num_errors = 0, comparisons = 0, n, tx_cnt = 0;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    // count tx write pulses where they are settled
    always @(negedge clk) tx_cnt += tx_wr;
    urm_host host (.clk(clk), .d_out(d_out), .d_oe(d_oe), .bus(bus));
    urm_top #(.REV_CODE(REV), .IDENT_CODE(IDENT)) dut (
        .CLK(clk), .RESETN(resetn), .CS_N(bus.cs_n), .RD_N(bus.rd_n), .WR_N(bus.wr_n),
        .ADDR(bus.addr), .D_IN(bus.data), .D_OUT(d_out), .D_OE(d_oe), .RX_VALID(rx_valid),
        .RX_DATA(rx_data), .RX_ERR(3'h0), .THR_EMPTY(1'b1), .TX_ALL_EMPTY(1'b1),
        .TX_WR(tx_wr), .TX_DATA(tx_data), .MODEM_N(modem_n), .LINE_CTRL(line_ctrl),
        .MODEM_CTRL(modem_ctrl), .TX_TRIG(tx_trig), .BAUD_TICK(baud_tick), .INT(irq));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one received character, line flipped after the pulse
    task automatic push(input logic [7:0] d);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = d;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data = ~d;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        chk({4'h0, d_oe, irq, baud_tick, tx_wr}, 8'h00);
        chk(line_ctrl, 8'h00);
        foreach (ROWS[i]) begin
            host.wr(3'h3, ROWS[i].line_control);
            host.wr(ROWS[i].a, ROWS[i].wd);
            host.rd(ROWS[i].a, r);
            chk(r, ROWS[i].ex);
        end
        chk(modem_ctrl, 8'he4);
        n = 0;
        repeat (50) @(negedge clk) n += baud_tick;
        chk(n[7:0], 8'h0a);
        host.wr(3'h0, 8'h77);
        chk(tx_data, 8'h77);
        chk(tx_cnt[7:0], 8'h01);
        host.rd(3'h2, r);
        chk(r, 8'h01);
        host.wr(3'h2, 8'h71);
        chk({6'h0, tx_trig}, 8'h03);
        host.rd(3'h2, r);
        chk(r, 8'hc1);
        for (int i = 0; i < 3; i++) push(8'h10 + i[7:0]);
        repeat (2) @(negedge clk);
        chk({7'h0, irq}, 8'h00);
        host.rd(3'h5, r);
        chk(r, 8'h61);
        push(8'h13);
        repeat (2) @(negedge clk);
        chk({7'h0, irq}, 8'h01);
        host.rd(3'h2, r);
        chk(r, 8'hc4);
        host.wr(3'h1, 8'h00);
        chk({7'h0, irq}, 8'h00);
        host.rd(3'h2, r);
        chk(r, 8'hc1);
        host.wr(3'h1, 8'h01);
        chk({7'h0, irq}, 8'h01);
        host.rd(3'h0, r);
        chk(r, 8'h10);
        chk({7'h0, irq}, 8'h00);
        host.rd(3'h2, r);
        chk(r, 8'hc1);
        host.rd(3'h0, r);
        host.rd(3'h0, r);
        chk(r, 8'h12);
        host.rd(3'h5, r);
        chk(r, 8'h61);
        host.rd(3'h0, r);
        host.rd(3'h5, r);
        chk(r, 8'h60);
        // modem source alone: one pin change raises the modem code
        host.wr(3'h1, 8'h08);
        @(negedge clk) modem_n = 4'he;
        repeat (6) @(negedge clk);
        chk({7'h0, irq}, 8'h01);
        host.rd(3'h2, r);
        chk(r, 8'hc0);
        host.rd(3'h6, r);
        chk(r, 8'h11);
        chk({7'h0, irq}, 8'h00);
        host.rd(3'h2, r);
        chk(r, 8'hc1);
        close_out();
    end
    // watchdog well beyond the expected run
    initial begin
        #200000;
        num_errors++;
        close_out();
    end
endmodule
bind urm_top urm_asserts chk_i (
    .CLK(CLK), .RESETN(RESETN), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .RX_VALID(RX_VALID),
    .D_OUT(D_OUT), .D_OE(D_OE), .TX_WR(TX_WR), .LINE_CTRL(LINE_CTRL),
    .MODEM_CTRL(MODEM_CTRL), .BAUD_TICK(BAUD_TICK), .INT(INT), .MODEM_N(MODEM_N));
